// ### design/fpe_flash_program_erase_controller.sv
// Flash program/erase sequencer: control/key registers, key arming,
// operation decode, self-timed cycle and processor stall.
// Assumes a strobe register port on sys_clk; rstn is the power-on reset.
`timescale 1ns/1ps
`default_nettype none

module fpe_flash_program_erase_controller #(
    parameter int CYCLE_SYS = fpe_pkg::FPE_ROW_SYS_CYC
) (
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    output logic                    cpu_stall,
    output logic                    flash_go,
    output fpe_pkg::fpe_act_e       flash_action,
    output logic      [23:0]        flash_addr
);
    import fpe_pkg::*;

    typedef struct packed {
        logic               start;
        logic               op_write_enable;
        logic               err;
        logic               erase;
        logic [3:0]         opcode;
        logic               key_half;
        logic               key_armed;
        logic [7:0]         page;
        logic [15:0]        offset;
        logic [FPE_IDX_W-1:0] buf_idx;
        logic [15:0]        buf_lo;
        logic [7:0]         buf_hi;
        logic [31:0]        timer;
        fpe_state_e         state;
        logic [15:0]        rdata;
        logic               stall;
        logic               go;
        fpe_act_e           action;
        logic [23:0]        addr;
    } fpe_state_s;

    fpe_state_s st_reg;
    fpe_state_s st_next;
    logic [23:0] buf_mem [FPE_BUF_DEPTH];
    logic        rst_sync1_reg;
    logic        rst_sync2_reg;
    logic        buf_we;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation decode for the selected mode
    function automatic fpe_act_e decode(input logic erase, input logic [3:0] op);
        fpe_act_e a;
        a = FPE_ACT_NONE;
        if (erase) begin
            case (op)
                FPE_OP_BULK:   a = FPE_ACT_BULK;
                FPE_OP_GENSEG: a = FPE_ACT_GENSEG;
                FPE_OP_SECSEG: a = FPE_ACT_SECSEG;
                FPE_OP_2:      a = FPE_ACT_PAGE_ER;
                FPE_OP_CFG:    a = FPE_ACT_CFG_ER;
                default:       a = FPE_ACT_NONE;
            endcase
        end else begin
            case (op)
                FPE_OP_3:      a = FPE_ACT_WORD_PR;
                FPE_OP_1:      a = FPE_ACT_ROW_PR;
                FPE_OP_CFG:    a = FPE_ACT_CFG_PR;
                default:       a = FPE_ACT_NONE;
            endcase
        end
        return a;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic wr_ctrl;
        logic wr_key;
        logic start_try;
        wr_ctrl   = reg_wr && (reg_addr == FPE_ADDR_CTRL);
        wr_key    = reg_wr && (reg_addr == FPE_ADDR_KEY);
        start_try = wr_ctrl && reg_wdata[FPE_BIT_START] && !st_reg.start;
        st_next    = st_reg;
        st_next.go = 1'b0;
        buf_we     = 1'b0;

        // Key sequence: only 0x55 directly followed by 0xAA arms
        if (wr_key) begin
            st_next.key_half  = (reg_wdata[7:0] == FPE_KEY_FIRST);
            st_next.key_armed = st_reg.key_half && (reg_wdata[7:0] == FPE_KEY_SECOND);
        end else if (reg_wr) begin
            st_next.key_half = 1'b0; // Any other write breaks the pair
            if (!wr_ctrl) begin
                st_next.key_armed = 1'b0;
            end
        end

        // Mode bits frozen while a cycle runs; the decode takes its inputs from the start write data
        if (wr_ctrl && (st_reg.state == FPE_ST_IDLE)) begin
            st_next.op_write_enable   = reg_wdata[FPE_BIT_OP_WRITE_ENABLE];
            st_next.erase  = reg_wdata[FPE_BIT_ERASE];
            st_next.opcode = reg_wdata[FPE_OP_MSB:0];
            if (!reg_wdata[FPE_BIT_ERR]) begin
                st_next.err = 1'b0; // Software may clear the flag
            end
        end

        // Start attempt: software can set but never clear the start bit
        if (start_try && (st_reg.state == FPE_ST_IDLE)) begin
            st_next.key_armed = 1'b0;
            st_next.key_half  = 1'b0;
            if (st_reg.key_armed && reg_wdata[FPE_BIT_OP_WRITE_ENABLE]) begin
                st_next.start  = 1'b1;
                st_next.err    = 1'b0;
                st_next.state  = FPE_ST_BUSY;
                st_next.stall  = 1'b1;
                st_next.timer  = CYCLE_SYS;
                st_next.go     = 1'b1;
                st_next.action = decode(reg_wdata[FPE_BIT_ERASE], reg_wdata[FPE_OP_MSB:0]);
                st_next.addr   = {st_reg.page, st_reg.offset};
            end else begin
                st_next.err = 1'b1;
            end
        end

        // Self-timed cycle
        case (st_reg.state)
            FPE_ST_IDLE: begin
            end
            FPE_ST_BUSY: begin
                if (st_reg.timer <= 32'h1) begin
                    st_next.state = FPE_ST_DONE;
                end else begin
                    st_next.timer = st_reg.timer - 32'h1;
                end
            end
            FPE_ST_DONE: begin
                st_next.start  = 1'b0;
                st_next.stall  = 1'b0;
                st_next.action = FPE_ACT_NONE;
                st_next.state  = FPE_ST_IDLE;
            end
            default: begin
                st_next.state = FPE_ST_IDLE;
            end
        endcase

        // Address and holding-buffer port, sequential fill from the index last written to BUFIDX
        if (reg_wr && (st_reg.state == FPE_ST_IDLE)) begin
            case (reg_addr)
                FPE_ADDR_PAGE:   st_next.page   = reg_wdata[7:0];
                FPE_ADDR_OFFSET: st_next.offset = reg_wdata;
                FPE_ADDR_BUFIDX: st_next.buf_idx = reg_wdata[FPE_IDX_W-1:0];
                FPE_ADDR_BUFLO:  st_next.buf_lo = reg_wdata;
                FPE_ADDR_BUFHI: begin
                    st_next.buf_hi  = reg_wdata[7:0];
                    st_next.buf_idx = st_reg.buf_idx + 1'b1;
                    buf_we          = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Read data one cycle after the strobe; unmapped reads zero
        st_next.rdata = 16'h0;
        if (reg_rd) begin
            case (reg_addr)
                FPE_ADDR_CTRL: begin
                    st_next.rdata[FPE_BIT_START] = st_reg.start;
                    st_next.rdata[FPE_BIT_OP_WRITE_ENABLE]  = st_reg.op_write_enable;
                    st_next.rdata[FPE_BIT_ERR]   = st_reg.err;
                    st_next.rdata[FPE_BIT_ERASE] = st_reg.erase;
                    st_next.rdata[FPE_OP_MSB:0]  = st_reg.opcode;
                end
                FPE_ADDR_KEY:    st_next.rdata = 16'h0;
                FPE_ADDR_PAGE:   st_next.rdata = {8'h0, st_reg.page};
                FPE_ADDR_OFFSET: st_next.rdata = st_reg.offset;
                FPE_ADDR_BUFIDX: st_next.rdata = {10'h0, st_reg.buf_idx};
                default:         st_next.rdata = 16'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; power-on reset clears every field
    always_ff @(posedge sys_clk or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Holding buffer storage; no reset needed for data words
    always_ff @(posedge sys_clk) begin
        if (buf_we) begin
            buf_mem[st_reg.buf_idx] <= {st_next.buf_hi, st_reg.buf_lo};
        end
    end

    assign reg_rdata    = st_reg.rdata;
    assign cpu_stall    = st_reg.stall;
    assign flash_go     = st_reg.go;
    assign flash_action = st_reg.action;
    assign flash_addr   = st_reg.addr;

endmodule : fpe_flash_program_erase_controller

`default_nettype wire

// ### design/fpe_pkg.sv
// Constants, register map and types for the flash program/erase sequencer.
// Assumes a single 250 MHz system clock and a simple strobe register port.
package fpe_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (word indices chosen for this port)
    localparam logic [3:0]  FPE_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  FPE_ADDR_KEY    = 4'h1;
    localparam logic [3:0]  FPE_ADDR_PAGE   = 4'h2;
    localparam logic [3:0]  FPE_ADDR_OFFSET = 4'h3;
    localparam logic [3:0]  FPE_ADDR_BUFIDX = 4'h4;
    localparam logic [3:0]  FPE_ADDR_BUFLO  = 4'h5;
    localparam logic [3:0]  FPE_ADDR_BUFHI  = 4'h6;

    // Control register fields
    localparam int          FPE_BIT_START   = 15;
    localparam int          FPE_BIT_OP_WRITE_ENABLE    = 14;
    localparam int          FPE_BIT_ERR     = 13;
    localparam int          FPE_BIT_ERASE   = 6;
    localparam int          FPE_OP_MSB      = 3;

    // Key values
    localparam logic [7:0]  FPE_KEY_FIRST   = 8'h55;
    localparam logic [7:0]  FPE_KEY_SECOND  = 8'haa;

    // Operation codes
    localparam logic [3:0]  FPE_OP_BULK     = 4'hf;
    localparam logic [3:0]  FPE_OP_GENSEG   = 4'hd;
    localparam logic [3:0]  FPE_OP_SECSEG   = 4'hc;
    localparam logic [3:0]  FPE_OP_3        = 4'h3;
    localparam logic [3:0]  FPE_OP_2        = 4'h2;
    localparam logic [3:0]  FPE_OP_1        = 4'h1;
    localparam logic [3:0]  FPE_OP_CFG      = 4'h0;

    // Decoded flash actions
    typedef enum logic [3:0] {
        FPE_ACT_NONE    = 4'h0,
        FPE_ACT_BULK    = 4'h1,
        FPE_ACT_GENSEG  = 4'h2,
        FPE_ACT_SECSEG  = 4'h3,
        FPE_ACT_PAGE_ER = 4'h4,
        FPE_ACT_CFG_ER  = 4'h5,
        FPE_ACT_WORD_PR = 4'h6,
        FPE_ACT_ROW_PR  = 4'h7,
        FPE_ACT_CFG_PR  = 4'h8
    } fpe_act_e;

    // Timing: oscillator cycles and rate, converted to system cycles
    localparam int          FPE_SYS_KHZ     = 250000;
    localparam int          FPE_OSC_KHZ     = 7370;
    localparam int          FPE_ROW_OSC_CYC = 11064;
    localparam int          FPE_ROW_SYS_CYC = (FPE_ROW_OSC_CYC * FPE_SYS_KHZ + FPE_OSC_KHZ - 1) / FPE_OSC_KHZ;

    // Holding buffer
    localparam int          FPE_BUF_DEPTH   = 64;
    localparam int          FPE_IDX_W       = 6;

    typedef enum logic [1:0] {
        FPE_ST_IDLE = 2'b00,
        FPE_ST_BUSY = 2'b01,
        FPE_ST_DONE = 2'b10
    } fpe_state_e;

endpackage : fpe_pkg

// ### testbench/fpe_monitor.sv
// Port-level checker for the flash program/erase sequencer.
// Assumes a bind from the bench top; rstn is the power-on reset.
`timescale 1ns/1ps
`default_nettype none

module fpe_monitor #(
    parameter int CYCLE_SYS = 20
) (
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic [3:0]        reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    input wire logic              cpu_stall,
    input wire logic              flash_go,
    input wire fpe_pkg::fpe_act_e flash_action,
    input wire logic [23:0]       flash_addr
);
    import fpe_pkg::*;

    logic       half_reg, armed_reg, rd_d_reg, stall_d_reg;
    logic [3:0] addr_d_reg;
    int         cnt_reg;
    logic       key_wr, ctl_start;

    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the key arming and of the read pipeline
    assign key_wr    = reg_wr && reg_addr == FPE_ADDR_KEY;
    assign ctl_start = reg_wr && reg_addr == FPE_ADDR_CTRL && reg_wdata[FPE_BIT_START];

    // Any non-key write breaks the pair, so a stray write between keys disarms
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            half_reg    <= 1'b0;
            armed_reg   <= 1'b0;
            rd_d_reg    <= 1'b0;
            stall_d_reg <= 1'b0;
            addr_d_reg  <= 4'h0;
            cnt_reg     <= 0;
        end else begin
            half_reg    <= key_wr ? (reg_wdata[7:0] == FPE_KEY_FIRST) : (reg_wr ? 1'b0 : half_reg);
            armed_reg   <= (key_wr && half_reg && reg_wdata[7:0] == FPE_KEY_SECOND) ? 1'b1 :
                           (reg_wr && (reg_addr != FPE_ADDR_CTRL || ctl_start)) ? 1'b0 : armed_reg;
            rd_d_reg    <= reg_rd;
            stall_d_reg <= cpu_stall;
            addr_d_reg  <= reg_addr;
            cnt_reg     <= cpu_stall ? cnt_reg + 1 : 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_launch; ctl_start && reg_wdata[FPE_BIT_OP_WRITE_ENABLE] && armed_reg && !cpu_stall |=> flash_go && cpu_stall; endproperty
    a_launch: assert property (p_launch) else $error("armed start did not launch");
    property p_refuse; ctl_start && !(reg_wdata[FPE_BIT_OP_WRITE_ENABLE] && armed_reg) |=> !flash_go; endproperty
    a_refuse: assert property (p_refuse) else $error("unarmed or disabled start launched");
    property p_go_cause; flash_go |-> $past(ctl_start) && $rose(cpu_stall); endproperty
    a_go_cause: assert property (p_go_cause) else $error("launch without a start write");
    property p_go_pulse; flash_go |=> !flash_go; endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("launch pulse too long");
    property p_stall_len; $fell(cpu_stall) |-> cnt_reg == CYCLE_SYS + 1; endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
    property p_hold; cpu_stall && !flash_go |-> $stable(flash_action) && $stable(flash_addr); endproperty
    a_hold: assert property (p_hold) else $error("action or address moved mid cycle");
    property p_idle_act; !cpu_stall |-> flash_action == FPE_ACT_NONE; endproperty
    a_idle_act: assert property (p_idle_act) else $error("action shown while idle");
    property p_key_read; rd_d_reg && addr_d_reg == FPE_ADDR_KEY |-> reg_rdata == 16'h0000; endproperty
    a_key_read: assert property (p_key_read) else $error("key register readable");
    property p_start_bit; rd_d_reg && addr_d_reg == FPE_ADDR_CTRL |-> reg_rdata[15] == stall_d_reg; endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit disagrees with cycle");
endmodule : fpe_monitor

`default_nettype wire

// ### testbench/test_flash_program_erase_controller.sv
// Self-checking bench for the flash program/erase sequencer.
// Assumes the design package is compiled first; binds the port checker.
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end

module test_flash_program_erase_controller;
    import fpe_pkg::*;

    localparam int CYC = 20;
    logic        sys_clk, rstn, reg_wr, reg_rd, cpu_stall, flash_go, rd_d;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, exp16;
    logic [23:0] flash_addr;
    logic [27:0] exp28;
    logic [31:0] seed;
    fpe_act_e    flash_action;
    logic [15:0] rd_q[$];
    logic [27:0] go_q[$];
    logic [3:0]  ops[8] = '{4'hf, 4'hd, 4'hc, 4'h3, 4'h2, 4'h1, 4'h0, 4'h5};
    int          bad_count, compares, cyc;

    fpe_flash_program_erase_controller #(.CYCLE_SYS(CYC)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_go(flash_go),
        .flash_action(flash_action), .flash_addr(flash_addr));

    ////////////////////////////////////////////////////////////////////////////
    // Stimulus helpers; strobes stay up between back-to-back calls
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic fpe_act_e exp_act(input logic e, input logic [3:0] op);
        case ({e, op})
            5'h1f: return FPE_ACT_BULK;
            5'h1d: return FPE_ACT_GENSEG;
            5'h1c: return FPE_ACT_SECSEG;
            5'h12: return FPE_ACT_PAGE_ER;
            5'h10: return FPE_ACT_CFG_ER;
            5'h03: return FPE_ACT_WORD_PR;
            5'h01: return FPE_ACT_ROW_PR;
            5'h00: return FPE_ACT_CFG_PR;
            default: return FPE_ACT_NONE;
        endcase
    endfunction : exp_act

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // Full keyed launch at a random target, then watch the start bit fall
    task automatic launch(input logic e, input logic [3:0] op);
        logic [31:0] r;
        r = rnd();
        wr(FPE_ADDR_PAGE, {8'h00, r[23:16]});
        wr(FPE_ADDR_OFFSET, r[15:0]);
        wr(FPE_ADDR_KEY, 16'h0055);
        wr(FPE_ADDR_KEY, 16'h00aa);
        wr(FPE_ADDR_CTRL, {2'b11, 7'h00, e, 2'b00, op});
        go_q.push_back({exp_act(e, op), r[23:0]});
        idle(2);
        rd(FPE_ADDR_CTRL, {2'b11, 7'h00, e, 2'b00, op});
        idle(1);
        for (int i = 0; i < CYC + 4 && cpu_stall === 1'b1; i++) @(posedge sys_clk);
        idle(2);
        rd(FPE_ADDR_CTRL, {2'b01, 7'h00, e, 2'b00, op});
        idle(1);
    endtask : launch

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    // Clock, scoreboard and timeout
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        rd_d <= reg_rd;
        cyc  <= cyc + 1;
        if (rd_d === 1'b1) begin
            exp16 = rd_q.pop_front();
            `CHK("rdata", exp16, reg_rdata)
        end
        if (flash_go === 1'b1) begin
            exp28 = go_q.pop_front();
            `CHK("launch", exp28, {flash_action, flash_addr})
        end
        if (cyc == 3000) begin
            bad_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: every code in both modes, then refused starts and reset
    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        seed = 32'd98123;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        idle(4);
        foreach (ops[i]) begin
            launch(1'b1, ops[i]);
            launch(1'b0, ops[i]);
        end
        wr(FPE_ADDR_CTRL, 16'hc001);
        idle(2);
        rd(FPE_ADDR_CTRL, 16'h6001);
        wr(FPE_ADDR_KEY, 16'h0055);
        wr(FPE_ADDR_KEY, 16'h00aa);
        wr(FPE_ADDR_CTRL, 16'h8001);
        idle(2);
        rd(FPE_ADDR_CTRL, 16'h2001);
        wr(FPE_ADDR_KEY, 16'h0055);
        wr(FPE_ADDR_PAGE, 16'h0001);
        wr(FPE_ADDR_KEY, 16'h00aa);
        wr(FPE_ADDR_CTRL, 16'hc001);
        idle(2);
        rd(FPE_ADDR_CTRL, 16'h6001);
        rd(FPE_ADDR_KEY, 16'h0000);
        rd(4'hf, 16'h0000);
        rd(FPE_ADDR_PAGE, 16'h0001);
        wr(FPE_ADDR_BUFIDX, 16'h003f);
        wr(FPE_ADDR_BUFLO, rnd());
        wr(FPE_ADDR_BUFHI, 16'h00a5);
        rd(FPE_ADDR_BUFIDX, 16'h0000);
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(4);
        rd(FPE_ADDR_CTRL, 16'h0000);
        idle(3);
        conclude();
    end
endmodule : test_flash_program_erase_controller

bind fpe_flash_program_erase_controller fpe_monitor #(.CYCLE_SYS(CYCLE_SYS)) u_mon (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .flash_go(flash_go),
    .flash_action(flash_action), .flash_addr(flash_addr));

`default_nettype wire
